// file: bench/adc_link_asserts.sv
/*
  Checker for the converter link: serial clock phases, data hold and
  calibration signalling on the ready pin and mode bits.
  Assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_link_asserts
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Link
  input wire logic       sclk,
  input wire logic       din,
  input wire logic       dout,
  input wire logic       ready_n,
  // Converter state
  input wire logic [2:0] op_select,
  input wire logic       calibrating,
  input wire logic       fir_bypass_eff,
  input wire logic       step_accel_eff
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sclk_low_len: assert property ($fell(sclk) |-> !sclk [*4] ##[1:2] sclk)
    else $error("serial clock low phase has wrong length");
  a_sclk_high_len: assert property ($rose(sclk) |-> sclk [*4])
    else $error("serial clock high phase too short");
  a_din_hold: assert property ($rose(sclk) |-> $stable(din))
    else $error("host data moved at serial clock rise");
  a_dout_hold: assert property ($rose(sclk) |-> $stable(dout))
    else $error("device data moved at serial clock rise");
  a_cal_busy: assert property (calibrating && $past(calibrating) |-> ready_n)
    else $error("ready pin low during calibration");
  a_cal_end_rdy: assert property ($fell(calibrating) |-> !ready_n)
    else $error("ready pin not low at calibration end");
  a_cal_end_idle: assert property ($fell(calibrating) |-> op_select == OP_IDLE)
    else $error("mode bits not idle at calibration end");
  a_cal_filter: assert property (calibrating |-> !fir_bypass_eff && !step_accel_eff)
    else $error("filter shortcuts active during calibration");
  a_cal_op: assert property ($rose(calibrating) |-> op_select[2])
    else $error("calibration started without calibration pattern");
  a_cal_op_hold: assert property (calibrating && $past(calibrating) |-> $stable(op_select))
    else $error("mode bits changed during calibration");
endmodule : adc_link_asserts
`default_nettype wire

// file: bench/testbench.sv
/*
  Bench: APB-driven host and converter joined by the link interface.
  Assumes the package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import adc_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [23:0] sample_data;
  logic        sample_valid;
  logic [2:0]  op_select;
  logic        calibrating;
  logic        fir_bypass_eff;
  logic        step_accel_eff;
  logic [2:0]  channel_select;
  logic        chop_enable;
  logic [23:0] conv_data;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          checked;
  int          cycles;
  // Calibration cases: pattern, filter setting, length
  logic [2:0]  cal_op  [6] = '{OP_INT_ZS, OP_INT_FS, OP_SYS_ZS, OP_SYS_FS, OP_INT_FS, OP_SYS_ZS};
  logic [15:0] cal_flt [6] = '{16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0003, 16'h0003};
  logic [5:0]  cal_len [6] = '{CAL_SHORT_CHOP, CAL_LONG_CHOP, CAL_SHORT_CHOP, CAL_SHORT_CHOP,
                               CAL_LONG_NOCH, CAL_SHORT_NOCH};

  adc_link_if link ();
  adc_device adc_device_inst (.pclk(pclk), .presetn(presetn), .link(link.dev), .sample_data(sample_data),
    .sample_valid(sample_valid), .op_select(op_select), .channel_select(channel_select), .chop_enable(chop_enable),
    .fir_bypass_eff(fir_bypass_eff), .step_accel_eff(step_accel_eff), .calibrating(calibrating),
    .conv_data(conv_data));
  adc_host adc_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link.host));
  adc_link_asserts adc_link_asserts_inst (.pclk(pclk), .presetn(presetn), .sclk(link.sclk), .din(link.din),
    .dout(link.dout), .ready_n(link.ready_n), .op_select(op_select), .calibrating(calibrating),
    .fir_bypass_eff(fir_bypass_eff), .step_accel_eff(step_accel_eff));

  always #(PCLK_NS / 2) pclk = ~pclk;

  task automatic print_verdict();
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== v && n < 2000);
    chk({31'h0, rd[b]}, {31'h0, v});
  endtask : poll

  // Whole link frame; leaves the received word in rd
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd);
    apb(1'b1, HA_WDATA, {8'h00, wd});
    apb(1'b1, HA_CMD, {24'h000000, cmd});
    poll(HA_STAT, 0, 1'b0);
    apb(1'b0, HA_RDATA, 32'h0);
  endtask : xfer

  task automatic pulses(input int k);
    repeat (k) begin
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : pulses

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_data = 24'h0;
    sample_valid = 1'b0;
    fails = 0;
    checked = 0;
    cycles = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, HA_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(8'h16, 24'h0);
    chk(rd, {8'h00, GAIN_RESET});
    xfer(8'h10, 24'h0);
    chk(rd, 32'h80);
    xfer(8'h11, 24'h0);
    chk(rd, 32'h0);
    xfer(8'h02, 24'h000001);
    chk({29'h0, channel_select}, 32'h1);
    xfer(8'h05, 24'h123456);
    xfer(8'h02, 24'h000000);
    xfer(8'h15, 24'h0);
    chk(rd, 32'h0);
    xfer(8'h02, 24'h000001);
    xfer(8'h15, 24'h0);
    chk(rd, 32'h123456);
    xfer(8'h02, 24'h000000);
    xfer(8'h14, 24'h0);
    xfer(8'h23, 24'h0);
    xfer(8'h00, 24'h0);
    xfer(8'h12, 24'h0);
    chk(rd, 32'h0);
    apb(1'b1, HA_IRQ_MASK, 32'h2);
    for (int i = 0; i < 6; i++) begin
      xfer(8'h03, {8'h00, cal_flt[i]});
      chk({31'h0, chop_enable}, {31'h0, cal_flt[i][FILT_CHOP_BIT]});
      sample_data <= cal_op[i][0] ? 24'h400123 : 24'h000123;
      xfer(8'h02, {8'h00, cal_op[i], 13'h0000});
      pulses(int'(cal_len[i]) - 1);
      chk({31'h0, link.ready_n}, 32'h1);
      xfer(8'h10, 24'h0);
      chk(rd, 32'hC0);
      pulses(1);
      chk({31'h0, link.ready_n}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, HA_IRQ_STAT, 32'h7);
      xfer(8'h12, 24'h0);
      chk(rd, 32'h0);
      xfer(cal_op[i][0] ? 8'h16 : 8'h15, 24'h0);
      chk(rd, cal_op[i][0] ? 32'h400000 : 32'h000123);
      chk({31'h0, irq}, 32'h0);
    end
    xfer(8'h05, 24'h000100);
    xfer(8'h06, 24'h400000);
    xfer(8'h02, 24'h002000);
    sample_data <= 24'h001100;
    pulses(1);
    chk({31'h0, link.ready_n}, 32'h0);
    chk({8'h00, conv_data}, 32'h800);
    xfer(8'h11, 24'h0);
    chk(rd, 32'h800);
    chk({31'h0, link.ready_n}, 32'h1);
    apb(1'b1, HA_CMD, 32'h20);
    poll(HA_IRQ_STAT, 2, 1'b1);
    apb(1'b0, HA_RDATA, 32'h0);
    chk(rd, 32'h80);
    apb(1'b1, HA_CMD, {24'h000000, CMD_STOP});
    poll(HA_STAT, 1, 1'b0);
    poll(HA_STAT, 0, 1'b0);
    xfer(8'h12, 24'h0);
    chk(rd, 32'h2000);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire

// file: verilog/adc_device.sv
/*
  Converter end: serial register access, calibration sequencing and
  offset/gain correction of filter samples.
  Assumes the host drives din after sclk falls and samples dout on rise;
  sclk idles high and is sampled on pclk.
*/
// Added by the designer: the placing of the registers and the APB slave port.
// Summary of operation
// - Six registers, reached via command byte first
// - Commands 10-16 read a register once
// - Commands 20-22 read repeatedly; 30 stops
// - No continuous read of filter/offset/gain
// - Commands 02-06 write; data read-only; 00 comm
// - Ready pin and bit high during calibration
// - Mode bits back to 000 at end
// - Skip and step bits ignored while calibrating
// - 100: internal zero-scale, 22/24 periods, offset
// - 101: internal full-scale, 44/48 periods, gain
// - 110: system zero-scale, 22/24 periods, offset
// - 111: system full-scale, 22/24 periods, gain
// - Host detects calibration end by ready
// - Host orders zero-scale and full-scale calibrations
// - Host picks calibration range for low ranges
// - Channel select picks the calibration pair
// - Data is offset-subtracted then gain-scaled
`timescale 1ns/1ps
`default_nettype none
module adc_device
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Serial link
  adc_link_if.dev          link,
  // Filter side
  input  wire logic [23:0] sample_data,
  input  wire logic        sample_valid,
  // Control and result
  output logic      [2:0]  op_select,
  output logic      [2:0]  channel_select,
  output logic             chop_enable,
  output logic             fir_bypass_eff,
  output logic             step_accel_eff,
  output logic             calibrating,
  output logic      [23:0] conv_data
);
  typedef enum logic [1:0] {ST_CMD, ST_READ, ST_WRITE, ST_CONT} ser_state_t;

  ser_state_t  state_reg;
  logic [2:0]  sclk_sync_reg;
  logic [1:0]  din_sync_reg;
  logic [23:0] rx_reg;
  logic [23:0] tx_reg;
  logic [4:0]  bit_cnt_reg;
  logic [4:0]  len_reg;
  logic [2:0]  idx_reg;
  logic [15:0] mode_reg;
  logic [15:0] filter_reg;
  logic [23:0] offset_reg [NUM_PAIRS];
  logic [23:0] gain_reg   [NUM_PAIRS];
  logic [23:0] data_reg;
  logic        ready_n_reg;
  logic        cal_reg;
  logic [5:0]  cal_cnt_reg;

  logic        rise, fall, last_bit, cmd_done, wr_stb, data_rd, cal_start, cal_end, conv_upd;
  logic [23:0] rx_next, wr_val, tx_word, corrected;
  logic [7:0]  cmd;
  logic [2:0]  tx_idx;
  logic [1:0]  pair;
  logic [5:0]  cal_len;
  logic [47:0] product;

  // Link pin synchronisers; only stage two onward is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_sync_reg <= 3'h7;
      din_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
      din_sync_reg  <= {din_sync_reg[0], link.din};
    end
  end

  assign rise     = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign fall     = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign rx_next  = {rx_reg[22:0], din_sync_reg[1]};
  assign cmd      = rx_next[7:0];
  assign last_bit = bit_cnt_reg == len_reg - 5'd1;
  assign cmd_done = rise && state_reg == ST_CMD && bit_cnt_reg == 5'd7;
  assign wr_stb   = rise && state_reg == ST_WRITE && last_bit;
  assign wr_val   = rx_next & (24'hFFFFFF >> (5'd24 - len_reg));
  assign tx_idx   = (state_reg == ST_CMD) ? cmd[2:0] : idx_reg;
  assign data_rd  = (cmd_done && (cmd[7:4] == CMD_RD_NIB || cmd[7:4] == CMD_CONT_NIB)
                     && cmd[3:0] == {1'b0, REG_DATA})
                    || (rise && state_reg == ST_CONT && last_bit && idx_reg == REG_DATA);

  // Calibration pair selected by channel field
  assign pair = (mode_reg[1:0] == 2'd3) ? 2'd2 : mode_reg[1:0];

  // Register contents presented on the link, left aligned
  always_comb begin
    case (tx_idx)
      REG_COMM:   tx_word = {ready_n_reg, cal_reg, 6'h00, 16'h0000};
      REG_DATA:   tx_word = data_reg;
      REG_MODE:   tx_word = {mode_reg, 8'h00};
      REG_FILTER: tx_word = {filter_reg, 8'h00};
      REG_OFFSET: tx_word = offset_reg[pair];
      REG_GAIN:   tx_word = gain_reg[pair];
      default:    tx_word = 24'h000000;
    endcase
  end

  // Serial command engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_CMD;
      rx_reg      <= 24'h000000;
      tx_reg      <= 24'h000000;
      bit_cnt_reg <= 5'd0;
      len_reg     <= 5'd8;
      idx_reg     <= REG_COMM;
    end else if (rise) begin
      rx_reg      <= rx_next;
      bit_cnt_reg <= bit_cnt_reg + 5'd1;
      case (state_reg)
        ST_CMD: begin
          if (bit_cnt_reg == 5'd7) begin
            bit_cnt_reg <= 5'd0;
            idx_reg     <= cmd[2:0];
            len_reg     <= reg_len(cmd[2:0]);
            tx_reg      <= tx_word;
            if (cmd[7:4] == CMD_RD_NIB && !cmd[3] && cmd[2:0] != 3'd4 && cmd[2:0] != 3'd7)
              state_reg <= ST_READ;
            else if (cmd[7:4] == CMD_CONT_NIB && cmd[3:0] <= 4'd2)
              state_reg <= ST_CONT;
            else if (cmd[7:4] == CMD_WR_NIB && (cmd[3:0] == 4'd2 || cmd[3:0] == 4'd3
                     || cmd[3:0] == 4'd5 || cmd[3:0] == 4'd6))
              state_reg <= ST_WRITE;
          end
        end
        ST_READ, ST_WRITE: begin
          if (last_bit) begin
            state_reg   <= ST_CMD;
            bit_cnt_reg <= 5'd0;
          end
        end
        ST_CONT: begin
          if (bit_cnt_reg[2:0] == 3'd7 && cmd == CMD_STOP) begin
            state_reg   <= ST_CMD;
            bit_cnt_reg <= 5'd0;
          end else if (last_bit) begin
            bit_cnt_reg <= 5'd0;
            tx_reg      <= tx_word;
          end
        end
        default: state_reg <= ST_CMD;
      endcase
    end else if (fall && (state_reg == ST_READ || state_reg == ST_CONT)) begin
      tx_reg <= {tx_reg[22:0], 1'b0};
    end
  end

  // Leading bit stands from load; covers the host's sampling lag
  assign link.dout = tx_reg[23];

  // Calibration control
  assign cal_start = wr_stb && idx_reg == REG_MODE && wr_val[MODE_OP_LSB+2];
  assign cal_end   = cal_reg && sample_valid && cal_cnt_reg == cal_len - 6'd1;
  always_comb begin
    if (mode_reg[MODE_OP_LSB+2:MODE_OP_LSB] == OP_INT_FS)
      cal_len = filter_reg[FILT_CHOP_BIT] ? CAL_LONG_CHOP : CAL_LONG_NOCH;
    else
      cal_len = filter_reg[FILT_CHOP_BIT] ? CAL_SHORT_CHOP : CAL_SHORT_NOCH;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_reg     <= 1'b0;
      cal_cnt_reg <= 6'd0;
    end else if (wr_stb && idx_reg == REG_MODE) begin
      cal_reg     <= cal_start;
      cal_cnt_reg <= 6'd0;
    end else if (cal_reg && sample_valid) begin
      cal_reg     <= !cal_end;
      cal_cnt_reg <= cal_cnt_reg + 6'd1;
    end
  end

  // Mode and filter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg   <= MODE_RESET;
      filter_reg <= FILTER_RESET;
    end else begin
      if (wr_stb && idx_reg == REG_MODE)
        mode_reg <= wr_val[15:0];
      else if (cal_end)
        mode_reg[MODE_OP_LSB+2:MODE_OP_LSB] <= OP_IDLE;
      if (wr_stb && idx_reg == REG_FILTER)
        filter_reg <= wr_val[15:0];
    end
  end

  // Calibration register pairs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        offset_reg[i] <= OFFSET_RESET;
        gain_reg[i]   <= GAIN_RESET;
      end
    end else if (cal_end) begin
      if (!mode_reg[MODE_OP_LSB])
        offset_reg[pair] <= sample_data;
      else
        gain_reg[pair] <= sample_data - offset_reg[pair];
    end else if (wr_stb && idx_reg == REG_OFFSET) begin
      offset_reg[pair] <= wr_val;
    end else if (wr_stb && idx_reg == REG_GAIN) begin
      gain_reg[pair] <= wr_val;
    end
  end

  // Corrected conversion result
  assign corrected = sample_data - offset_reg[pair];
  assign product   = corrected * gain_reg[pair];
  assign conv_upd  = sample_valid && !cal_reg && mode_reg[MODE_OP_LSB+2:MODE_OP_LSB] != OP_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      data_reg <= 24'h000000;
    else if (conv_upd)
      data_reg <= product[46:23];
  end

  // Ready indication; new result wins over a data read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ready_n_reg <= 1'b1;
    else if (cal_start)
      ready_n_reg <= 1'b1;
    else if (cal_end || conv_upd)
      ready_n_reg <= 1'b0;
    else if (data_rd)
      ready_n_reg <= 1'b1;
  end

  assign link.ready_n   = ready_n_reg;
  assign op_select      = mode_reg[MODE_OP_LSB+2:MODE_OP_LSB];
  assign channel_select = mode_reg[2:0];
  assign chop_enable    = filter_reg[FILT_CHOP_BIT];
  assign fir_bypass_eff = filter_reg[FILT_SKIP_BIT] & ~cal_reg;
  assign step_accel_eff = filter_reg[FILT_STEP_BIT] & ~cal_reg;
  assign calibrating    = cal_reg;
  assign conv_data      = data_reg;
endmodule : adc_device
`default_nettype wire

// file: verilog/adc_host.sv
/*
  Host end: APB-programmed serial master for the converter link with
  sticky, maskable interrupts.
  Assumes an APB master on pclk; the converter samples sclk on its clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_host
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Serial link
  adc_link_if.host         link
);
  logic        busy_reg, cont_reg, stop_reg, sclk_reg, din_reg;
  logic [3:0]  div_reg;
  logic [5:0]  bits_reg;
  logic [4:0]  len_reg;
  logic [31:0] tx_reg;
  logic [23:0] rx_reg, rdata_reg, wdata_reg;
  logic [2:0]  irq_stat_reg, irq_mask_reg, ev;
  logic [1:0]  dout_sync_reg;
  logic [2:0]  rdy_sync_reg;
  logic        wr, rd_ok, tick, h_rise, word_end, start, rdy_fall;
  logic        rd_cmd, ct_cmd, wr_cmd;
  logic [7:0]  new_cmd;
  logic [4:0]  new_len;
  logic [23:0] rx_next;

  assign wr      = psel && penable && pwrite;
  assign new_cmd = pwdata[7:0];
  assign new_len = reg_len(new_cmd[2:0]);
  // Refused commands carry no data bits
  assign rd_cmd  = new_cmd[7:4] == CMD_RD_NIB && !new_cmd[3] && new_cmd[2:0] != 3'd4 && new_cmd[2:0] != 3'd7;
  assign ct_cmd  = new_cmd[7:4] == CMD_CONT_NIB && new_cmd[3:0] <= 4'd2;
  assign wr_cmd  = new_cmd[7:4] == CMD_WR_NIB && (new_cmd[3:0] == 4'd2 || new_cmd[3:0] == 4'd3
                   || new_cmd[3:0] == 4'd5 || new_cmd[3:0] == 4'd6);
  assign start   = wr && paddr == HA_CMD && !busy_reg;
  assign rd_ok   = paddr == HA_CMD || paddr == HA_WDATA || paddr == HA_RDATA
                   || paddr == HA_STAT || paddr == HA_IRQ_STAT || paddr == HA_IRQ_MASK;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  always_comb begin
    case (paddr)
      HA_WDATA:    prdata = {8'h00, wdata_reg};
      HA_RDATA:    prdata = {8'h00, rdata_reg};
      HA_STAT:     prdata = {29'h0, rdy_sync_reg[1], cont_reg, busy_reg};
      HA_IRQ_STAT: prdata = {29'h0, irq_stat_reg};
      HA_IRQ_MASK: prdata = {29'h0, irq_mask_reg};
      default:     prdata = 32'h00000000;
    endcase
  end

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_sync_reg <= 2'h0;
      rdy_sync_reg  <= 3'h7;
    end else begin
      dout_sync_reg <= {dout_sync_reg[0], link.dout};
      rdy_sync_reg  <= {rdy_sync_reg[1:0], link.ready_n};
    end
  end

  // Serial clock divider
  assign tick = busy_reg && div_reg == 4'(SCLK_HALF_CYC - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      div_reg <= 4'h0;
    else if (!busy_reg || tick)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end

  assign h_rise   = tick && !sclk_reg;
  assign word_end = h_rise && bits_reg == 6'd1;
  assign rx_next  = {rx_reg[22:0], dout_sync_reg[1]};

  // Frame engine: command byte, then data out or in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cont_reg <= 1'b0;
      sclk_reg <= 1'b1;
      din_reg  <= 1'b0;
      bits_reg <= 6'd0;
      len_reg  <= 5'd8;
      tx_reg   <= 32'h00000000;
      rx_reg   <= 24'h000000;
    end else if (start) begin
      busy_reg <= 1'b1;
      len_reg  <= new_len;
      cont_reg <= ct_cmd;
      if (wr_cmd) begin
        bits_reg <= 6'd8 + 6'(new_len);
        tx_reg   <= {new_cmd, wdata_reg << (5'd24 - new_len)};
      end else if (rd_cmd || ct_cmd) begin
        bits_reg <= 6'd8 + 6'(new_len);
        tx_reg   <= {new_cmd, 24'h000000};
      end else begin
        bits_reg <= 6'd8;
        tx_reg   <= {new_cmd, 24'h000000};
      end
    end else if (tick && sclk_reg) begin
      sclk_reg <= 1'b0;
      din_reg  <= tx_reg[31];
      tx_reg   <= {tx_reg[30:0], 1'b0};
    end else if (h_rise) begin
      sclk_reg <= 1'b1;
      rx_reg   <= rx_next;
      bits_reg <= bits_reg - 6'd1;
      if (word_end) begin
        if (cont_reg && stop_reg) begin
          bits_reg <= 6'd8;
          tx_reg   <= {CMD_STOP, 24'h000000};
          cont_reg <= 1'b0;
        end else if (cont_reg) begin
          bits_reg <= 6'(len_reg);
        end else begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  // Stop request for continuous mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stop_reg <= 1'b0;
    else if (word_end && cont_reg && stop_reg)
      stop_reg <= 1'b0;
    else if (wr && paddr == HA_CMD && cont_reg && new_cmd == CMD_STOP)
      stop_reg <= 1'b1;
  end

  // Software data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_reg <= 24'h000000;
      rdata_reg <= 24'h000000;
    end else begin
      if (wr && paddr == HA_WDATA)
        wdata_reg <= pwdata[23:0];
      if (word_end && (cont_reg || len_reg != 5'd0))
        rdata_reg <= rx_next & (24'hFFFFFF >> (5'd24 - len_reg));
    end
  end

  // Interrupts: sticky, write one to clear, set wins
  assign rdy_fall = rdy_sync_reg[2] && !rdy_sync_reg[1];
  assign ev = {word_end && cont_reg, rdy_fall, word_end && !cont_reg};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      if (wr && paddr == HA_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | ev;
      else
        irq_stat_reg <= irq_stat_reg | ev;
      if (wr && paddr == HA_IRQ_MASK)
        irq_mask_reg <= pwdata[2:0];
    end
  end

  assign irq       = |(irq_stat_reg & irq_mask_reg);
  assign link.sclk = sclk_reg;
  assign link.din  = din_reg;
endmodule : adc_host
`default_nettype wire

// file: verilog/adc_link_if.sv
/*
  Three-wire serial link plus ready pin between host and converter.
  Assumes the bench instantiates it and binds both modports.
*/
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic sclk;
  logic din;
  logic dout;
  logic ready_n;
  modport dev  (input sclk, input din, output dout, output ready_n);
  modport host (output sclk, output din, input dout, input ready_n);
endinterface : adc_link_if
`default_nettype wire

// file: verilog/adc_pkg.sv
/*
  Shared constants for the converter serial link: command codes,
  register indices and lengths, calibration lengths, host register map.
  Assumes pclk at 125 MHz.
*/
package adc_pkg;
  localparam int          PCLK_NS        = 8;
  localparam int          SCLK_PERIOD_NS = 80;
  localparam int          SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * PCLK_NS);
  // Command byte fields
  localparam logic [3:0]  CMD_WR_NIB     = 4'h0;
  localparam logic [3:0]  CMD_RD_NIB     = 4'h1;
  localparam logic [3:0]  CMD_CONT_NIB   = 4'h2;
  localparam logic [7:0]  CMD_STOP       = 8'h30;
  // Register indices
  localparam logic [2:0]  REG_COMM       = 3'h0;
  localparam logic [2:0]  REG_DATA       = 3'h1;
  localparam logic [2:0]  REG_MODE       = 3'h2;
  localparam logic [2:0]  REG_FILTER     = 3'h3;
  localparam logic [2:0]  REG_OFFSET     = 3'h5;
  localparam logic [2:0]  REG_GAIN       = 3'h6;
  // Field positions
  localparam int          MODE_OP_LSB    = 13;
  localparam int          FILT_CHOP_BIT  = 2;
  localparam int          FILT_SKIP_BIT  = 1;
  localparam int          FILT_STEP_BIT  = 0;
  localparam int          STAT_RDY_BIT   = 7;
  localparam int          STAT_CAL_BIT   = 6;
  // Operation patterns
  localparam logic [2:0]  OP_IDLE        = 3'h0;
  localparam logic [2:0]  OP_INT_ZS      = 3'h4;
  localparam logic [2:0]  OP_INT_FS      = 3'h5;
  localparam logic [2:0]  OP_SYS_ZS      = 3'h6;
  localparam logic [2:0]  OP_SYS_FS      = 3'h7;
  // Calibration lengths in output periods
  localparam logic [5:0]  CAL_SHORT_CHOP = 6'd22;
  localparam logic [5:0]  CAL_SHORT_NOCH = 6'd24;
  localparam logic [5:0]  CAL_LONG_CHOP  = 6'd44;
  localparam logic [5:0]  CAL_LONG_NOCH  = 6'd48;
  // Reset values
  localparam logic [15:0] MODE_RESET     = 16'h0000;
  localparam logic [15:0] FILTER_RESET   = 16'h0004;
  localparam logic [23:0] OFFSET_RESET   = 24'h000000;
  localparam logic [23:0] GAIN_RESET     = 24'h800000;
  localparam int          NUM_PAIRS      = 3;
  // Host register map (byte addresses)
  localparam logic [7:0]  HA_CMD         = 8'h00;
  localparam logic [7:0]  HA_WDATA       = 8'h04;
  localparam logic [7:0]  HA_RDATA       = 8'h08;
  localparam logic [7:0]  HA_STAT        = 8'h0C;
  localparam logic [7:0]  HA_IRQ_STAT    = 8'h10;
  localparam logic [7:0]  HA_IRQ_MASK    = 8'h14;
  localparam int          IRQ_XFER_DONE  = 0;
  localparam int          IRQ_CAL_DONE   = 1;
  localparam int          IRQ_WORD       = 2;

  // Bits carried by a register on the link
  function automatic logic [4:0] reg_len(input logic [2:0] idx);
    case (idx)
      REG_DATA, REG_OFFSET, REG_GAIN: reg_len = 5'd24;
      REG_MODE, REG_FILTER:           reg_len = 5'd16;
      default:                        reg_len = 5'd8;
    endcase
  endfunction : reg_len
endpackage : adc_pkg
